// ---- src/adc_register_access_wait.sv ----
// Wait request generator for CPU accesses to the converter register set
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Writes to mode, channel-select or port-config registers and reads of any result register stall the CPU.
// - The stall in CPU clocks is twice the CPU clock over the conversion clock.
// - A fraction of one half or less is dropped and more than one half rounds up.
// - Conversion clock divisors 1, 2, 3, 4, 6, 8 and 12 of the peripheral clock are all accepted.
// - With a shared source clock the stall spans 1-4,1-6,1-8,1-12,1-16,1-24 for divisors 2,3,4,6,8,12.
// - Longest stall at full CPU speed and slowest conversion clock, shortest at CPU/16 and fastest.
// - The tabulated ranges hold only for a shared source; other pairings use the computation.
module adc_register_access_wait (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_access,
    input wire logic i_write,
    input wire logic [3:0] i_reg_sel,
    input wire logic [2:0] i_conv_div,
    input wire logic [2:0] i_cpu_div,
    input wire logic i_periph_clk_run,
    output logic o_wait_req,
    output logic o_access_done,
    output logic o_stopped_clk_err
);
    import adc_wait_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01
    } state_t;

    state_t state_q;
    state_t state_d;
    logic [5:0] count_q;
    logic [5:0] count_d;
    logic wait_q;
    logic done_q;
    logic err_q;
    logic [5:0] calc_wait;

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    wire is_ctrl_reg = (i_reg_sel == SEL_CONV_MODE) || (i_reg_sel == SEL_CHANNEL_SELECT)
        || (i_reg_sel == SEL_PORT_CFG_0) || (i_reg_sel == SEL_PORT_CFG_1);
    wire is_result_reg = (i_reg_sel >= SEL_RESULT) && (i_reg_sel <= SEL_RESULT_X1_LOW);
    wire stall_access = i_access && ((i_write && is_ctrl_reg) || (!i_write && is_result_reg));
    // Stopped peripheral clock is the CPU's fault; flag it rather than hang
    wire bad_access = stall_access && !i_periph_clk_run;
    wire start = (state_q == ST_IDLE) && stall_access && i_periph_clk_run;

    // Count follows the formula for any clock pairing, not a fixed table
    adc_wait_calc u_calc (
        .i_conv_div(i_conv_div),
        .i_cpu_div(i_cpu_div),
        .o_wait_cnt(calc_wait)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_WAIT;
                    count_d = calc_wait;
                end
            end
            ST_WAIT: begin
                count_d = 6'(count_q - 6'h01);
                if (count_q == WAIT_MIN) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                count_d = '0;
            end
        endcase
    end

    // Wait stands exactly calc_wait cycles, then one done pulse
    wire wait_d = (state_d == ST_WAIT);
    wire done_d = (state_q == ST_WAIT) && (state_d == ST_IDLE);

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            count_q <= '0;
            wait_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            wait_q <= wait_d;
            done_q <= done_d;
            err_q <= bad_access;
        end
    end

    assign o_wait_req = wait_q;
    assign o_access_done = done_q;
    assign o_stopped_clk_err = err_q;
endmodule : adc_register_access_wait

// ---- src/adc_wait_pkg.sv ----
// Constants for the converter register access wait generator
package adc_wait_pkg;
    // Converter register selectors on the CPU side
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_CONV_MODE = 4'h1;
    localparam logic [3:0] SEL_CHANNEL_SELECT = 4'h2;
    localparam logic [3:0] SEL_PORT_CFG_0 = 4'h3;
    localparam logic [3:0] SEL_PORT_CFG_1 = 4'h4;
    localparam logic [3:0] SEL_RESULT = 4'h5;
    localparam logic [3:0] SEL_RESULT_HIGH = 4'h6;
    localparam logic [3:0] SEL_RESULT_LOW = 4'h7;
    localparam logic [3:0] SEL_RESULT_X0 = 4'h8;
    localparam logic [3:0] SEL_RESULT_X1 = 4'h9;
    localparam logic [3:0] SEL_RESULT_X0_LOW = 4'hA;
    localparam logic [3:0] SEL_RESULT_X1_LOW = 4'hB;
    // Conversion clock divisor codes: peripheral clock divided by 1,2,3,4,6,8,12
    localparam logic [2:0] DIV_1 = 3'h0;
    localparam logic [2:0] DIV_2 = 3'h1;
    localparam logic [2:0] DIV_3 = 3'h2;
    localparam logic [2:0] DIV_4 = 3'h3;
    localparam logic [2:0] DIV_6 = 3'h4;
    localparam logic [2:0] DIV_8 = 3'h5;
    localparam logic [2:0] DIV_12 = 3'h6;
    // CPU clock ratio codes: main clock divided by 2^code, code 0..4
    localparam logic [2:0] CPU_DIV_MAX = 3'h4;
    // Stall factor and rounding
    localparam int unsigned WAIT_FACTOR = 2;
    localparam int unsigned FRAC_BITS = 4;
    localparam logic [3:0] HALF_FRAC = 4'h8;
    localparam int unsigned WAIT_W = 6;
    localparam logic [5:0] WAIT_MIN = 6'h01;
endpackage : adc_wait_pkg

// ---- src/adc_wait_calc.sv ----
// Stall count calculator: 2 * f_cpu / f_conv, rounded at one half
`timescale 1ns/10ps
module adc_wait_calc (
    input wire logic [2:0] i_conv_div,
    input wire logic [2:0] i_cpu_div,
    output logic [5:0] o_wait_cnt
);
    import adc_wait_pkg::*;

    // f_cpu/f_conv = div_conv / 2^cpu_div, so stall = 2*div_conv / 2^cpu_div
    logic [4:0] conv_div_val;
    logic [9:0] scaled;
    logic [9:0] shifted;
    logic [5:0] whole;
    logic [3:0] frac;
    logic [5:0] rounded;

    always_comb begin
        case (i_conv_div)
            DIV_1: conv_div_val = 5'h01;
            DIV_2: conv_div_val = 5'h02;
            DIV_3: conv_div_val = 5'h03;
            DIV_4: conv_div_val = 5'h04;
            DIV_6: conv_div_val = 5'h06;
            DIV_8: conv_div_val = 5'h08;
            DIV_12: conv_div_val = 5'h0C;
            default: conv_div_val = 5'h0C; // Unused code: slowest, safest stall
        endcase
    end

    // Fixed point with four fraction bits, enough for a shift of up to 4
    assign scaled = 10'(conv_div_val * WAIT_FACTOR) << FRAC_BITS;
    assign shifted = scaled >> ((i_cpu_div > CPU_DIV_MAX) ? CPU_DIV_MAX : i_cpu_div);
    assign whole = 6'(shifted >> FRAC_BITS);
    assign frac = shifted[3:0];
    assign rounded = (frac > HALF_FRAC) ? 6'(whole + 6'h01) : whole;
    // A stall never drops under one clock
    assign o_wait_cnt = (rounded < WAIT_MIN) ? WAIT_MIN : rounded;
endmodule : adc_wait_calc

// ---- verif/adc_wait_checker_assertions.sv ----
// Assertions for the converter register wait generator
`timescale 1ns/10ps
module adc_wait_checker import adc_wait_pkg::*; (
    input wire logic i_sys_clk, i_reset, i_access, i_write, i_periph_clk_run,
    input wire logic o_wait_req, o_access_done, o_stopped_clk_err,
    input wire logic [3:0] i_reg_sel,
    input wire logic [2:0] i_conv_div, i_cpu_div
);
    localparam int dv[8] = '{1, 2, 3, 4, 6, 8, 12, 12};
    logic [5:0] cnt_q, exp_q;
    logic stall;
    assign stall = i_access && !o_wait_req && (i_write ? i_reg_sel inside {[SEL_CONV_MODE:SEL_PORT_CFG_1]}
        : i_reg_sel inside {[SEL_RESULT:SEL_RESULT_X1_LOW]});
    function automatic logic [5:0] calc(input logic [2:0] d, input logic [2:0] c);
        int v = 2 * dv[d];
        int s = (c > CPU_DIV_MAX) ? 4 : int'(c);
        calc = 6'((v >> s) + int'(2 * (v % (1 << s)) > (1 << s)));
        if (calc == 6'h00) calc = WAIT_MIN;
    endfunction : calc
    always_ff @(posedge i_sys_clk) begin
        cnt_q <= (i_reset || !o_wait_req) ? 6'h00 : cnt_q + 6'h01;
        if (stall && i_periph_clk_run) exp_q <= calc(i_conv_div, i_cpu_div);
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence end_s; $fell(o_wait_req); endsequence
    wait_start_a: assert property (stall && i_periph_clk_run |=> o_wait_req)
        else $error("no stall");
    no_wait_a: assert property (i_access && !o_wait_req && !stall |=> !o_wait_req)
        else $error("stray stall");
    wait_len_a: assert property (end_s |-> cnt_q == exp_q)
        else $error("stall length");
    done_after_a: assert property (end_s |-> o_access_done)
        else $error("no done");
    done_pulse_a: assert property (o_access_done |=> !o_access_done)
        else $error("done held");
    done_cause_a: assert property (o_access_done |-> $past(o_wait_req))
        else $error("stray done");
    stop_err_a: assert property (stall && !i_periph_clk_run |=> o_stopped_clk_err && !o_wait_req)
        else $error("no error");
endmodule : adc_wait_checker
bind adc_register_access_wait adc_wait_checker chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_access(i_access),
    .i_write(i_write), .i_periph_clk_run(i_periph_clk_run), .o_wait_req(o_wait_req), .o_access_done(o_access_done),
    .o_stopped_clk_err(o_stopped_clk_err), .i_reg_sel(i_reg_sel), .i_conv_div(i_conv_div), .i_cpu_div(i_cpu_div));

// ---- verif/cpu_model.sv ----
// CPU core model issuing converter register accesses
`timescale 1ns/10ps
module cpu_model (
    input wire logic i_sys_clk, i_wait_req, i_access_done,
    output logic o_access = 1'b0, o_write = 1'b0,
    output logic [3:0] o_reg_sel = 4'h0
);
    // Counts stall cycles; a silent access gives up after 40 cycles
    task automatic run(input logic w, input logic [3:0] sel, output int n);
        @(posedge i_sys_clk);
        o_access <= 1'b1;
        o_write <= w;
        o_reg_sel <= sel;
        @(posedge i_sys_clk);
        o_access <= 1'b0;
        o_write <= ~w;
        o_reg_sel <= ~sel;
        n = 0;
        for (int k = 0; k < 40; k++) begin
            #1;
            if (i_access_done === 1'b1) break;
            n += int'(i_wait_req === 1'b1);
            @(posedge i_sys_clk);
        end
    endtask : run
endmodule : cpu_model

// ---- verif/adc_register_access_wait_tb.sv ----
// Self-checking bench for the converter register wait generator
`timescale 1ns/10ps
module adc_register_access_wait_tb;
    import adc_wait_pkg::*;
    logic i_sys_clk = 1'b0, i_reset = 1'b1, i_periph_clk_run = 1'b1, i_access, i_write;
    logic o_wait_req, o_access_done, o_stopped_clk_err;
    logic [2:0] i_conv_div = DIV_4, i_cpu_div = 3'h0;
    logic [3:0] i_reg_sel;
    int bad_count = 0, comparisons = 0, cycles = 0, errs = 0, dones = 0, n;
    localparam int dv[7] = '{1, 2, 3, 4, 6, 8, 12};
    adc_register_access_wait uut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_access(i_access), .i_write(i_write),
        .i_reg_sel(i_reg_sel), .i_conv_div(i_conv_div), .i_cpu_div(i_cpu_div), .i_periph_clk_run(i_periph_clk_run),
        .o_wait_req(o_wait_req), .o_access_done(o_access_done), .o_stopped_clk_err(o_stopped_clk_err));
    cpu_model cpu (.i_sys_clk(i_sys_clk), .i_wait_req(o_wait_req), .i_access_done(o_access_done),
        .o_access(i_access), .o_write(i_write), .o_reg_sel(i_reg_sel));
    task automatic check(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            bad_count++;
            $display("unexpected at %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic wait_table;
        int q;
        for (int d = 0; d < 7; d++) begin
            for (int c = 0; c < 5; c++) begin
                @(posedge i_sys_clk);
                i_conv_div <= 3'(d);
                i_cpu_div <= 3'(c);
                q = (64 * dv[d]) >> c;
                cpu.run(1'b1, SEL_CONV_MODE, n);
                check(n, (q < 32) ? 1 : q / 32 + int'(q % 32 > 16));
            end
        end
        $display("table done");
    endtask : wait_table
    task automatic reg_kinds;
        @(posedge i_sys_clk);
        i_conv_div <= DIV_4;
        i_cpu_div <= 3'h0;
        for (int s = 0; s < 12; s++) begin
            cpu.run(1'b1, 4'(s), n);
            check(n, (s inside {[1:4]}) ? 8 : 0);
            cpu.run(1'b0, 4'(s), n);
            check(n, (s > 4) ? 8 : 0);
        end
        $display("selectors done");
    endtask : reg_kinds
    task automatic stopped_clk;
        @(posedge i_sys_clk);
        i_periph_clk_run <= 1'b0;
        cpu.run(1'b0, SEL_RESULT_X1_LOW, n);
        check(n, 0);
        check(errs, 1);
        // One done per stalling access: 35 table entries plus 11 stalling selectors
        check(dones, 46);
        @(posedge i_sys_clk);
        i_periph_clk_run <= 1'b1;
        $display("stopped clock done");
    endtask : stopped_clk
    initial begin
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    // Error pulses are tallied here so no single-cycle pulse slips between task samples
    always @(posedge i_sys_clk) begin
        cycles++;
        errs += int'(o_stopped_clk_err === 1'b1);
        dones += int'(o_access_done === 1'b1);
        if (cycles == 5000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        wait_table();
        reg_kinds();
        stopped_clk();
        give_verdict();
    end
endmodule : adc_register_access_wait_tb
